/* src/rcs_core.sv */
// execution core: register file, alu, status flags, pc, stack, io access
// assumes decoded ops, and io and program memory answer in the cycle that shows the address
//
// Contract
// - immediate ops and load immediate write only registers 16 to 31
// - register ops reach all 32 registers directly in one cycle
// - registers 30 and 31 form the pointer; high byte ignored for register access
// - read two operands, compute and write back within one cycle
// - nine-bit program counter over 512 sixteen-bit words
// - register indirect uses the register indexed by the pointer low byte
// - two-register ops read source and destination, write destination
// - io direct address is a six-bit instruction field
// - relative jump and call go to pc plus offset plus one
// - program memory byte load: pointer bits 9..1 word, bit 0 byte
// - three-level, nine-bit return stack for calls and interrupts
// - call or interrupt pushes into level 0, shifting levels deeper
// - returns load pc from level 0 and shift levels up
// - overflow drops oldest; pop keeps the deepest level
// - io read and write move data between registers and io space
// - io bit set, clear and skip only for addresses below 0x20
// - global enable low blocks interrupts; cleared on entry, set on interrupt return
// - bit store copies to copy flag, bit load copies it back
// - sign flag always equals negative xor overflow
// - status flags at io 0x3f, fixed bit layout, reset zero
// - io space of 64 locations
`timescale 1ns/1ps
module rcs_core
  import rcs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_op_valid,
  input wire rcs_pkg::rcs_op_t i_op,
  input wire logic [4:0] i_rd,
  input wire logic [4:0] i_rr,
  input wire logic [7:0] i_imm,
  input wire logic [5:0] i_io_addr,
  input wire logic [2:0] i_bit,
  input wire logic [11:0] i_offset,
  input wire logic i_irq_req,
  input wire logic [8:0] i_irq_vector,
  input wire logic [15:0] i_pmem_data,
  input wire logic [7:0] i_io_rdata,
  output logic o_ready,
  output logic [8:0] o_pc,
  output logic [8:0] o_pmem_addr,
  output logic [5:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  output logic o_io_we,
  output logic o_io_re,
  output logic [7:0] o_status,
  output logic o_irq_ack
);
  logic [7:0] rf_reg [RCS_RF_N];
  logic [7:0] rf_next [RCS_RF_N];
  logic [8:0] pc_reg, pc_next, pmem_addr_reg, pmem_addr_next;
  logic [5:0] io_addr_reg, io_addr_next;
  logic [7:0] io_wdata_reg, io_wdata_next, status_reg, status_next;
  logic io_we_reg, io_we_next, io_re_reg, io_re_next, ready_reg, ready_next, ack_reg, ack_next;
  rcs_state_t state_reg, state_next;
  rcs_op_t pend_op_reg, pend_op_next;
  logic [4:0] pend_rd_reg, pend_rd_next;
  logic [2:0] pend_bit_reg, pend_bit_next;
  logic pend_lsb_reg, pend_lsb_next;
  logic take, irq_take, imm_op;
  logic [4:0] dst;
  logic [7:0] a, b, res, lpm_byte;
  logic [8:0] rel_tgt;
  logic [15:0] ptr;
  rcs_stack_if sif ();

  rcs_ret_stack u_stack (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .sif(sif)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // =====================================================================
  // operand selection
  assign take = i_op_valid && ready_reg && (state_reg == ST_IDLE);
  assign irq_take = !ready_reg && (state_reg == ST_IDLE) && i_irq_req && status_reg[RCS_F_I];
  assign imm_op = (i_op inside {OP_SUB_IMM, OP_SUB_CARRY_IMM, OP_COMPARE_IMM, OP_AND_IMM,
                                OP_OR_IMM, OP_LOAD_IMM});
  assign dst = imm_op ? {1'b1, i_rd[3:0]} : i_rd;
  assign ptr = {rf_reg[RCS_PTR_HI_IDX], rf_reg[RCS_PTR_LO_IDX]};
  assign a = rf_reg[dst];
  assign b = imm_op ? i_imm : rf_reg[i_rr];
  assign rel_tgt = pc_reg + i_offset[8:0] + 9'h001;
  assign lpm_byte = pend_lsb_reg ? i_pmem_data[15:8] : i_pmem_data[7:0];

  // =====================================================================
  // next state of the whole datapath
  always_comb
  begin
    logic [8:0] sum;
    logic wr_en, cin, lat_z;
    logic [7:0] fl;
    sum = 9'h000;
    wr_en = 1'b0;
    cin = status_reg[RCS_F_C];
    lat_z = 1'b0;
    fl = status_reg;
    res = a;
    for (int i = 0; i < RCS_RF_N; i++)
    begin
      rf_next[i] = rf_reg[i];
    end
    pc_next = pc_reg;
    pmem_addr_next = pmem_addr_reg;
    io_addr_next = io_addr_reg;
    io_wdata_next = io_wdata_reg;
    io_we_next = 1'b0;
    io_re_next = 1'b0;
    ack_next = 1'b0;
    state_next = state_reg;
    pend_op_next = pend_op_reg;
    pend_rd_next = pend_rd_reg;
    pend_bit_next = pend_bit_reg;
    pend_lsb_next = pend_lsb_reg;
    sif.push = 1'b0;
    sif.pop = 1'b0;
    sif.push_addr = pc_reg;
    if (irq_take)
    begin
      sif.push = 1'b1;
      pc_next = i_irq_vector;
      fl[RCS_F_I] = 1'b0;
      ack_next = 1'b1;
    end
    else if (take)
    begin
      pc_next = pc_reg + 9'h001;
      pend_op_next = i_op;
      pend_rd_next = i_rd;
      pend_bit_next = i_bit;
      io_addr_next = i_io_addr;
      case (i_op)
        OP_ADD, OP_ADD_CARRY:
        begin
          sum = {1'b0, a} + {1'b0, b} + {8'h00, (i_op == OP_ADD_CARRY) & cin};
          res = sum[7:0];
          wr_en = 1'b1;
          fl[RCS_F_C] = sum[8];
          fl[RCS_F_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
          fl[RCS_F_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
        end
        OP_SUB, OP_SUB_CARRY, OP_COMPARE, OP_SUB_IMM, OP_SUB_CARRY_IMM, OP_COMPARE_IMM:
        begin
          lat_z = (i_op == OP_SUB_CARRY) || (i_op == OP_SUB_CARRY_IMM);
          sum = {1'b0, a} - {1'b0, b} - {8'h00, lat_z & cin};
          res = sum[7:0];
          wr_en = (i_op != OP_COMPARE) && (i_op != OP_COMPARE_IMM);
          fl[RCS_F_C] = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
          fl[RCS_F_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
          fl[RCS_F_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
        end
        OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR:
        begin
          res = (i_op == OP_XOR) ? (a ^ b) : ((i_op == OP_AND) || (i_op == OP_AND_IMM)) ? (a & b) : (a | b);
          wr_en = 1'b1;
          fl[RCS_F_V] = 1'b0;
        end
        OP_INC, OP_DEC:
        begin
          res = (i_op == OP_INC) ? (a + 8'h01) : (a - 8'h01);
          wr_en = 1'b1;
          fl[RCS_F_V] = (i_op == OP_INC) ? (res == 8'h80) : (res == 8'h7f);
        end
        OP_NOT:
        begin
          res = ~a;
          wr_en = 1'b1;
          fl[RCS_F_C] = 1'b1;
          fl[RCS_F_V] = 1'b0;
        end
        OP_NEGATE:
        begin
          res = 8'h00 - a;
          wr_en = 1'b1;
          fl[RCS_F_C] = (res != 8'h00);
          fl[RCS_F_V] = (res == 8'h80);
          fl[RCS_F_H] = res[3] | a[3];
        end
        OP_SHIFT_RIGHT, OP_ROTATE_RIGHT, OP_ARITH_RIGHT:
        begin
          res = {(i_op == OP_ROTATE_RIGHT) ? cin : (i_op == OP_ARITH_RIGHT) ? a[7] : 1'b0, a[7:1]};
          wr_en = 1'b1;
          fl[RCS_F_C] = a[0];
          fl[RCS_F_V] = res[7] ^ a[0];
        end
        OP_SWAP_NIBBLE, OP_MOVE, OP_LOAD_IMM:
        begin
          res = (i_op == OP_SWAP_NIBBLE) ? {a[3:0], a[7:4]} : b;
          rf_next[dst] = res;
        end
        OP_IND_LOAD:
        begin
          rf_next[i_rd] = rf_reg[rf_reg[RCS_PTR_LO_IDX][4:0]];
        end
        OP_IND_STORE:
        begin
          rf_next[rf_reg[RCS_PTR_LO_IDX][4:0]] = rf_reg[i_rd];
        end
        OP_REL_JUMP:
        begin
          pc_next = rel_tgt;
        end
        OP_REL_CALL:
        begin
          sif.push = 1'b1;
          sif.push_addr = pc_reg + 9'h001;
          pc_next = rel_tgt;
        end
        OP_SUB_RETURN, OP_IRQ_RETURN:
        begin
          sif.pop = 1'b1;
          pc_next = sif.top_addr;
          if (i_op == OP_IRQ_RETURN)
          begin
            fl[RCS_F_I] = 1'b1;
          end
        end
        OP_PMEM_LOAD:
        begin
          pmem_addr_next = ptr[9:1];
          pend_lsb_next = ptr[0];
          state_next = ST_PMEM_WAIT;
        end
        OP_IO_READ:
        begin
          if (i_io_addr == RCS_STATUS_ADDR)
          begin
            rf_next[i_rd] = status_reg;
          end
          else
          begin
            io_re_next = 1'b1;
            state_next = ST_IO_WAIT;
          end
        end
        OP_IO_WRITE:
        begin
          if (i_io_addr == RCS_STATUS_ADDR)
          begin
            fl = rf_reg[i_rd];
          end
          else
          begin
            io_we_next = 1'b1;
            io_wdata_next = rf_reg[i_rd];
          end
        end
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLEAR:
        begin
          if (i_io_addr < RCS_BIT_IO_LIMIT)
          begin
            io_re_next = 1'b1;
            state_next = ST_IO_WAIT;
          end
        end
        OP_BIT_STORE:
        begin
          fl[RCS_F_T] = a[i_bit];
        end
        OP_BIT_LOAD:
        begin
          rf_next[i_rd][i_bit] = status_reg[RCS_F_T];
        end
        OP_FLAG_SET, OP_FLAG_CLEAR:
        begin
          fl[i_bit] = (i_op == OP_FLAG_SET);
        end
        default:
        begin
          res = a;
        end
      endcase
      if (wr_en)
      begin
        rf_next[dst] = res;
      end
      if (wr_en || (i_op == OP_COMPARE) || (i_op == OP_COMPARE_IMM))
      begin
        fl[RCS_F_N] = res[7];
        fl[RCS_F_Z] = lat_z ? ((res == 8'h00) & status_reg[RCS_F_Z]) : (res == 8'h00);
      end
    end
    else if (state_reg == ST_PMEM_WAIT)
    begin
      rf_next[RCS_LPM_DEST_IDX] = lpm_byte;
      pmem_addr_next = pc_reg;
      state_next = ST_IDLE;
    end
    else if (state_reg == ST_IO_WAIT)
    begin
      state_next = ST_IDLE;
      case (pend_op_reg)
        OP_IO_READ:
        begin
          rf_next[pend_rd_reg] = i_io_rdata;
        end
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
        begin
          io_we_next = 1'b1;
          io_wdata_next = i_io_rdata;
          io_wdata_next[pend_bit_reg] = (pend_op_reg == OP_IO_BIT_SET);
        end
        OP_SKIP_BIT_SET, OP_SKIP_BIT_CLEAR:
        begin
          if (i_io_rdata[pend_bit_reg] == (pend_op_reg == OP_SKIP_BIT_SET))
          begin
            pc_next = pc_reg + 9'h001;
          end
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
    fl[RCS_F_S] = fl[RCS_F_N] ^ fl[RCS_F_V];
    status_next = fl;
    if (state_next == ST_IDLE && state_reg == ST_IDLE)
    begin
      pmem_addr_next = (state_next == ST_IDLE && !(take && i_op == OP_PMEM_LOAD)) ? pc_next : pmem_addr_next;
    end
    ready_next = (state_next == ST_IDLE) && !(i_irq_req && status_next[RCS_F_I] && !irq_take);
  end

  // =====================================================================
  // registers
  generate
    for (genvar g = 0; g < RCS_RF_N; g++)
    begin : g_rf
      always_ff @(posedge i_mclk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          rf_reg[g] <= 8'h00;
        end
        else
        begin
          rf_reg[g] <= rf_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pc_reg <= RCS_PC_RESET;
      pmem_addr_reg <= RCS_PC_RESET;
      io_addr_reg <= 6'h00;
      io_wdata_reg <= 8'h00;
      io_we_reg <= 1'b0;
      io_re_reg <= 1'b0;
      status_reg <= RCS_STATUS_RESET;
      ready_reg <= 1'b0;
      ack_reg <= 1'b0;
      state_reg <= ST_IDLE;
      pend_op_reg <= OP_NOP;
      pend_rd_reg <= 5'h00;
      pend_bit_reg <= 3'h0;
      pend_lsb_reg <= 1'b0;
    end
    else
    begin
      pc_reg <= pc_next;
      pmem_addr_reg <= pmem_addr_next;
      io_addr_reg <= io_addr_next;
      io_wdata_reg <= io_wdata_next;
      io_we_reg <= io_we_next;
      io_re_reg <= io_re_next;
      status_reg <= status_next;
      ready_reg <= ready_next;
      ack_reg <= ack_next;
      state_reg <= state_next;
      pend_op_reg <= pend_op_next;
      pend_rd_reg <= pend_rd_next;
      pend_bit_reg <= pend_bit_next;
      pend_lsb_reg <= pend_lsb_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_pc = pc_reg;
  assign o_pmem_addr = pmem_addr_reg;
  assign o_io_addr = io_addr_reg;
  assign o_io_wdata = io_wdata_reg;
  assign o_io_we = io_we_reg;
  assign o_io_re = io_re_reg;
  assign o_status = status_reg;
  assign o_irq_ack = ack_reg;

  // =====================================================================
  // checks
  a_imm_upper_dest: assert property ((take && i_op == OP_LOAD_IMM) |=>
      rf_reg[{1'b1, $past(i_rd[3:0])}] == $past(i_imm))
    else $error("load immediate missed the upper register");
  a_alu_one_cycle: assert property ((take && i_op == OP_ADD) |=>
      rf_reg[$past(dst)] == $past(a) + $past(b))
    else $error("add result not written in one cycle");
  a_ind_by_low_ptr: assert property ((take && i_op == OP_IND_LOAD && i_rd != RCS_PTR_LO_IDX) |=>
      rf_reg[$past(i_rd)] == $past(rf_reg[rf_reg[RCS_PTR_LO_IDX][4:0]]))
    else $error("indirect load used the wrong register");
  a_rel_target: assert property ((take && i_op inside {OP_REL_JUMP, OP_REL_CALL}) |=>
      pc_reg == $past(rel_tgt))
    else $error("relative target wrong");
  a_pmem_byte_sel: assert property ((take && i_op == OP_PMEM_LOAD) |=>
      (o_pmem_addr == $past(ptr[9:1])) && !o_ready ##1 rf_reg[0] == $past(lpm_byte))
    else $error("program memory byte load wrong");
  a_ret_from_top: assert property ((take && i_op == OP_SUB_RETURN) |=> pc_reg == $past(sif.top_addr))
    else $error("return did not use stack level 0");
  a_bit_io_limit: assert property ((take && i_op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} &&
      i_io_addr[5]) |=> !o_io_re && !o_io_we && (state_reg == ST_IDLE))
    else $error("bit access above the low io range");
  a_irq_clears_glob: assert property (irq_take |=> !o_status[RCS_F_I] && o_irq_ack && o_pc == $past(i_irq_vector))
    else $error("interrupt entry wrong");
  a_irq_blocked: assert property (!status_reg[RCS_F_I] |=> !o_irq_ack)
    else $error("interrupt taken while globally disabled");
  a_sign_xor: assert property (o_status[RCS_F_S] == (o_status[RCS_F_N] ^ o_status[RCS_F_V]))
    else $error("sign flag not n xor v");
  a_bit_store_copy: assert property ((take && i_op == OP_BIT_STORE) |=> o_status[RCS_F_T] == $past(a[i_bit]))
    else $error("bit store did not reach the copy flag");
endmodule // rcs_core

/* src/rcs_pkg.sv */
// package of the core datapath: widths, register map, flag layout, op codes
// assumes one system clock and an external decoder that feeds decoded ops
package rcs_pkg;
  // =====================================================================
  // widths and sizes
  localparam int unsigned RCS_PC_W = 9;
  localparam int unsigned RCS_IO_AW = 6;
  localparam int unsigned RCS_RF_N = 32;
  localparam int unsigned RCS_STACK_N = 3;
  localparam int unsigned RCS_OFF_W = 12;
  // =====================================================================
  // register map and reset values
  localparam logic [5:0] RCS_STATUS_ADDR = 6'h3f;
  localparam logic [7:0] RCS_STATUS_RESET = 8'h00;
  localparam logic [5:0] RCS_BIT_IO_LIMIT = 6'h20;
  localparam logic [8:0] RCS_PC_RESET = 9'h000;
  localparam logic [4:0] RCS_PTR_LO_IDX = 5'h1e;
  localparam logic [4:0] RCS_PTR_HI_IDX = 5'h1f;
  localparam logic [4:0] RCS_LPM_DEST_IDX = 5'h00;
  // =====================================================================
  // status_flags bit positions
  localparam int unsigned RCS_F_C = 0;
  localparam int unsigned RCS_F_Z = 1;
  localparam int unsigned RCS_F_N = 2;
  localparam int unsigned RCS_F_V = 3;
  localparam int unsigned RCS_F_S = 4;
  localparam int unsigned RCS_F_H = 5;
  localparam int unsigned RCS_F_T = 6;
  localparam int unsigned RCS_F_I = 7;
  // =====================================================================
  // decoded operations
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADD_CARRY = 6'h02, OP_SUB = 6'h03,
    OP_SUB_CARRY = 6'h04, OP_AND = 6'h05, OP_OR = 6'h06, OP_XOR = 6'h07,
    OP_MOVE = 6'h08, OP_COMPARE = 6'h09, OP_SUB_IMM = 6'h0a, OP_SUB_CARRY_IMM = 6'h0b,
    OP_COMPARE_IMM = 6'h0c, OP_AND_IMM = 6'h0d, OP_OR_IMM = 6'h0e, OP_LOAD_IMM = 6'h0f,
    OP_INC = 6'h10, OP_DEC = 6'h11, OP_NOT = 6'h12, OP_NEGATE = 6'h13,
    OP_SHIFT_RIGHT = 6'h14, OP_ROTATE_RIGHT = 6'h15, OP_ARITH_RIGHT = 6'h16, OP_SWAP_NIBBLE = 6'h17,
    OP_IND_LOAD = 6'h18, OP_IND_STORE = 6'h19, OP_REL_JUMP = 6'h1a, OP_REL_CALL = 6'h1b,
    OP_SUB_RETURN = 6'h1c, OP_IRQ_RETURN = 6'h1d, OP_PMEM_LOAD = 6'h1e, OP_IO_READ = 6'h1f,
    OP_IO_WRITE = 6'h20, OP_IO_BIT_SET = 6'h21, OP_IO_BIT_CLEAR = 6'h22, OP_SKIP_BIT_SET = 6'h23,
    OP_SKIP_BIT_CLEAR = 6'h24, OP_BIT_STORE = 6'h25, OP_BIT_LOAD = 6'h26, OP_FLAG_SET = 6'h27,
    OP_FLAG_CLEAR = 6'h28
  } rcs_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IO_WAIT = 2'b01,
    ST_PMEM_WAIT = 2'b10
  } rcs_state_t;
endpackage

/* src/rcs_stack_if.sv */
// carrier between the core and its return-address stack
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface rcs_stack_if;
  logic push;
  logic pop;
  logic [8:0] push_addr;
  logic [8:0] top_addr;
  modport core (output push, output pop, output push_addr, input top_addr);
  modport stack (input push, input pop, input push_addr, output top_addr);
endinterface

/* src/rcs_ret_stack.sv */
// three-level return-address stack
// assumes push and pop never come in the same cycle
`timescale 1ns/1ps
module rcs_ret_stack
  import rcs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  rcs_stack_if.stack sif
);
  logic [RCS_PC_W-1:0] lvl_reg [RCS_STACK_N];
  logic [RCS_PC_W-1:0] lvl_next [RCS_STACK_N];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // =====================================================================
  // next level contents
  always_comb
  begin
    for (int i = 0; i < RCS_STACK_N; i++)
    begin
      lvl_next[i] = lvl_reg[i];
    end
    if (sif.push)
    begin
      lvl_next[0] = sif.push_addr;
      lvl_next[1] = lvl_reg[0];
      lvl_next[2] = lvl_reg[1];
    end
    else if (sif.pop)
    begin
      lvl_next[0] = lvl_reg[1];
      lvl_next[1] = lvl_reg[2];
    end
  end

  generate
    for (genvar g = 0; g < RCS_STACK_N; g++)
    begin : g_lvl
      always_ff @(posedge i_mclk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          lvl_reg[g] <= RCS_PC_RESET;
        end
        else
        begin
          lvl_reg[g] <= lvl_next[g];
        end
      end
    end
  endgenerate

  assign sif.top_addr = lvl_reg[0];

  // =====================================================================
  // checks
  a_push_shifts_down: assert property (sif.push |=> (lvl_reg[0] == $past(sif.push_addr)) &&
      (lvl_reg[1] == $past(lvl_reg[0])) && (lvl_reg[2] == $past(lvl_reg[1])))
    else $error("push did not shift the stack down");
  a_pop_keeps_deep: assert property ((sif.pop && !sif.push) |=> (lvl_reg[0] == $past(lvl_reg[1])) &&
      (lvl_reg[2] == $past(lvl_reg[2])))
    else $error("pop lost the deepest level");
endmodule // rcs_ret_stack

/* bench/rcs_partner.sv */
// program memory and io register model facing the core
// assumes reads answer in the cycle that shows the address
`timescale 1ns/1ps
module rcs_partner (
  input wire logic i_mclk,
  input wire logic [8:0] i_pmem_addr,
  input wire logic [5:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_we,
  input wire logic i_io_re,
  output logic [15:0] o_pmem_data,
  output logic [7:0] o_io_rdata
);
  // =====
  // storage
  logic [7:0] io_mem [64] = '{default: 8'h00};
  logic [7:0] last_q = 8'h00;
  assign o_pmem_data = {i_pmem_addr[7:0] ^ 8'ha5, i_pmem_addr[7:0]};
  // inverse of last value when not read
  assign o_io_rdata = i_io_re ? io_mem[i_io_addr] : ~last_q;
  always @(posedge i_mclk)
  begin
    if (i_io_we)
      io_mem[i_io_addr] <= i_io_wdata;
    last_q <= o_io_rdata;
  end
endmodule // rcs_partner

/* bench/tb_cpu_core_regfile_stack.sv */
// self-checking bench for the core datapath
// assumes rcs_partner as program memory and io space
`timescale 1ns/1ps
module tb_cpu_core_regfile_stack;
  import rcs_pkg::*;
  // =====
  // signals
  logic i_mclk, i_nrst, i_op_valid, i_irq_req, o_ready, o_io_we, o_io_re, o_irq_ack;
  rcs_op_t i_op;
  logic [4:0] i_rd, i_rr;
  logic [7:0] i_imm, i_io_rdata, o_io_wdata, o_status, a, s;
  logic [5:0] i_io_addr, o_io_addr;
  logic [2:0] i_bit, bt;
  logic [11:0] i_offset;
  logic [8:0] i_irq_vector, o_pc, o_pmem_addr, exp_pc, ret [4];
  logic [15:0] i_pmem_data;
  logic [13:0] exp_q [$];
  logic [11:0] ks [3] = '{12'h900, 12'h7ff, 12'h800};
  int fails = 0;
  int cmp_count = 0;
  int acks = 0;
  rcs_op_t alu_ops [21] = '{OP_LOAD_IMM, OP_SUB, OP_SUB_CARRY_IMM, OP_ADD_CARRY, OP_INC, OP_DEC, OP_AND_IMM,
    OP_XOR, OP_OR_IMM, OP_COMPARE_IMM, OP_ARITH_RIGHT, OP_ROTATE_RIGHT, OP_NOT, OP_NEGATE, OP_SHIFT_RIGHT,
    OP_SWAP_NIBBLE, OP_OR, OP_AND, OP_SUB_IMM, OP_COMPARE, OP_SUB_CARRY};
  logic [7:0] alu_exp [21] = '{8'h35, 8'hd9, 8'ha3, 8'hff, 8'h00, 8'hff, 8'h35, 8'h69, 8'h7d, 8'h7d, 8'h3e,
    8'h9f, 8'h60, 8'ha0, 8'h50, 8'h05, 8'h5d, 8'h5c, 8'h27, 8'h27, 8'hca};
  rcs_core dut_u (.i_mclk, .i_nrst, .i_op_valid, .i_op, .i_rd, .i_rr, .i_imm, .i_io_addr, .i_bit,
    .i_offset, .i_irq_req, .i_irq_vector, .i_pmem_data, .i_io_rdata, .o_ready, .o_pc, .o_pmem_addr,
    .o_io_addr, .o_io_wdata, .o_io_we, .o_io_re, .o_status, .o_irq_ack);
  rcs_partner mdl_u (.i_mclk, .i_pmem_addr(o_pmem_addr), .i_io_addr(o_io_addr), .i_io_wdata(o_io_wdata),
    .i_io_we(o_io_we), .i_io_re(o_io_re), .o_pmem_data(i_pmem_data), .o_io_rdata(i_io_rdata));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // =====
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (e !== g)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // entered at a rising edge; returns at the edge that takes the op
  task automatic op(input rcs_op_t c, input logic [4:0] d, input logic [4:0] r, input logic [7:0] m,
    input logic [5:0] io, input logic [2:0] b, input logic [11:0] k);
    int n;
    n = 0;
    i_op_valid <= 1'b1;
    i_op <= c;
    i_rd <= d;
    i_rr <= r;
    i_imm <= m;
    i_io_addr <= io;
    i_bit <= b;
    i_offset <= k;
    do
    begin
      @(negedge i_mclk);
      n++;
    end while (o_ready !== 1'b1 && n < 40);
    if (n >= 40)
      chk("ready", 1, 0);
    @(posedge i_mclk);
    exp_pc = exp_pc + 9'h001;
  endtask
  task automatic wr(input logic [4:0] r, input logic [5:0] io, input logic [7:0] e);
    exp_q.push_back({io, e});
    op(OP_IO_WRITE, r, r, '0, io, '0, '0);
  endtask
  task automatic pcc();
    i_op_valid <= 1'b0;
    repeat (2) @(negedge i_mclk);
    chk("pc", exp_pc, o_pc);
    @(posedge i_mclk);
  endtask
  // =====
  // monitor and watchdog
  always @(posedge i_mclk)
  begin
    if (o_irq_ack === 1'b1)
      acks <= acks + 1;
    if (o_io_we === 1'b1)
      chk("io_write", exp_q.size() > 0 ? exp_q.pop_front() : 14'h3fff, {o_io_addr, o_io_wdata});
  end
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
  // =====
  // tests
  initial
  begin
    void'($urandom(32'h05d7));
    a = 8'($urandom);
    bt = 3'($urandom);
    exp_pc = '0;
    i_nrst = 1'b0;
    i_op_valid = 1'b0;
    i_irq_req = 1'b0;
    i_irq_vector = 9'h004;
    i_op = OP_NOP;
    {i_rd, i_rr, i_imm, i_io_addr, i_bit, i_offset} = '0;
    repeat (8) @(posedge i_mclk);
    chk("status", 8'h00, o_status);
    chk("pc", 9'h000, o_pc);
    i_nrst <= 1'b1;
    op(OP_LOAD_IMM, 5'h01, '0, a, '0, '0, '0);
    op(OP_LOAD_IMM, 5'h12, '0, 8'h5c, '0, '0, '0);
    op(OP_ADD, 5'h11, 5'h12, '0, '0, '0, '0);
    s = a + 8'h5c;
    op(OP_MOVE, 5'h02, 5'h11, '0, '0, '0, '0);
    wr(5'h02, 6'h18, s);
    op(OP_LOAD_IMM, 5'h0f, '0, 8'hf1, '0, '0, '0);
    for (int i = 0; i < 2; i++)
    begin
      op(OP_LOAD_IMM, 5'h0e, '0, 8'h06 + 8'(i), '0, '0, '0);
      op(OP_PMEM_LOAD, '0, '0, '0, '0, '0, '0);
      wr(5'h00, 6'h17, i > 0 ? 8'h26 : 8'h83);
    end
    op(OP_LOAD_IMM, 5'h0e, '0, 8'h11, '0, '0, '0);
    op(OP_IND_LOAD, 5'h04, '0, '0, '0, '0, '0);
    wr(5'h04, 6'h32, s);
    op(OP_BIT_STORE, 5'h11, '0, '0, '0, bt, '0);
    op(OP_BIT_LOAD, 5'h05, '0, '0, '0, 3'h7, '0);
    wr(5'h05, 6'h2e, {s[bt], 7'h00});
    op(OP_LOAD_IMM, 5'h04, '0, 8'h1c, '0, '0, '0);
    op(OP_IO_WRITE, 5'h14, 5'h14, '0, 6'h3f, '0, '0);
    op(OP_IO_READ, 5'h07, 5'h07, '0, 6'h3f, '0, '0);
    wr(5'h07, 6'h2d, 8'h0c);
    op(OP_IO_BIT_SET, '0, '0, '0, 6'h2e, bt, '0);
    exp_q.push_back({6'h18, s | (8'h01 << bt)});
    op(OP_IO_BIT_SET, '0, '0, '0, 6'h18, bt, '0);
    exp_q.push_back({6'h18, s & ~(8'h01 << bt)});
    op(OP_IO_BIT_CLEAR, '0, '0, '0, 6'h18, bt, '0);
    op(OP_SKIP_BIT_SET, '0, '0, '0, 6'h18, bt, '0);
    op(OP_SKIP_BIT_CLEAR, '0, '0, '0, 6'h18, bt, '0);
    exp_pc = exp_pc + 9'h001;
    pcc();
    foreach (ks[j])
    begin
      op(OP_REL_JUMP, '0, '0, '0, '0, '0, ks[j]);
      exp_pc = exp_pc + ks[j][8:0];
      pcc();
    end
    for (int i = 0; i < 4; i++)
    begin
      op(OP_REL_CALL, '0, '0, '0, '0, '0, 12'h010);
      ret[i] = exp_pc;
      exp_pc = exp_pc + 9'h010;
    end
    pcc();
    for (int i = 3; i >= 0; i--)
    begin
      op(OP_SUB_RETURN, '0, '0, '0, '0, '0, '0);
      exp_pc = ret[i > 0 ? i : 1];
      pcc();
    end
    i_irq_req <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk("irq_ack", 0, 16'(acks));
    i_irq_req <= 1'b0;
    op(OP_FLAG_SET, '0, '0, '0, '0, 3'h7, '0);
    i_op_valid <= 1'b0;
    i_irq_req <= 1'b1;
    ret[0] = exp_pc;
    for (int n = 0; n < 20 && acks == 0; n++)
      @(negedge i_mclk);
    @(posedge i_mclk);
    i_irq_req <= 1'b0;
    exp_pc = i_irq_vector;
    pcc();
    chk("irq_en", 0, o_status[7]);
    chk("irq_ack", 1, 16'(acks));
    op(OP_IRQ_RETURN, '0, '0, '0, '0, '0, '0);
    exp_pc = ret[0];
    pcc();
    chk("irq_en", 1, o_status[7]);
    foreach (alu_ops[j])
    begin
      op(alu_ops[j], 5'h13, 5'h12, 8'h35, '0, '0, '0);
      wr(5'h13, 6'h18, alu_exp[j]);
    end
    op(OP_IND_STORE, 5'h13, '0, '0, '0, '0, '0);
    wr(5'h11, 6'h18, 8'hca);
    op(OP_FLAG_CLEAR, '0, '0, '0, '0, 3'h7, '0);
    pcc();
    chk("irq_en", 0, o_status[7]);
    chk("queue", 0, 16'(exp_q.size()));
    stop_test();
  end
endmodule // tb_cpu_core_regfile_stack
